// File: clock_select_params.svh
// Constants for the system clock source selection block.
// Assumes a 4-bit word index on the register port and 32-bit data.
`ifndef CLOCK_SELECT_PARAMS_SVH
`define CLOCK_SELECT_PARAMS_SVH

// Register word offsets
`define OFS_SYSTEM_CONTROL_REG0 4'h0
`define OFS_PLL_CONTROL_REG0 4'h1
`define OFS_PRESCALE_REG 4'h2
`define OFS_STATUS_REG 4'h3

// Field positions, system_control_reg0
`define SYSCTL_SEL_LSB 0
`define SYSCTL_SEL_MSB 1
`define SYSCTL_DIRECT_XTAL 2

// Field positions, pll_control_reg0
`define PLLCTL_BYPASS 0
`define PLLCTL_BAND_LSB 1
`define PLLCTL_BAND_MSB 2
`define PLLCTL_REF_INT 3
`define PLLCTL_P_LSB 4
`define PLLCTL_P_MSB 7
`define PLLCTL_N_LSB 8
`define PLLCTL_N_MSB 14
`define PLLCTL_K2_LSB 16
`define PLLCTL_K2_MSB 22

// Field positions, prescale and status registers
`define PRESC_K1_LSB 0
`define PRESC_K1_MSB 9
`define STATUS_MODE_LSB 0
`define STATUS_MODE_MSB 3
`define STATUS_LOCK 4

// Source select codes
`define SEL_WAKEUP 2'h0
`define SEL_RESERVED 2'h1
`define SEL_OSC 2'h2
`define SEL_DIRECT 2'h3

// Reset values
`define RST_SEL 2'h0
`define RST_BYPASS 1'h1
`define RST_BAND 2'h0
`define RST_VCO_PERIOD 16'h0010

// VCO half-period limits per band, in system-side clock cycles
`define BAND0_PER_MIN 16'h0002
`define BAND0_PER_MAX 16'h0FFF
`define BAND1_PER_MIN 16'h0001
`define BAND1_PER_MAX 16'h07FF

`endif

// File: clock_select_pkg.sv
// Types shared by the system clock source selection block.
// Assumes the constants header is compiled alongside.
package clock_select_pkg;

  // Active generation method, one-hot
  typedef enum logic [3:0] {
    MODE_WAKEUP = 4'b0001,
    MODE_PRESC = 4'b0010,
    MODE_PLL = 4'b0100,
    MODE_DIRECT = 4'b1000
  } clk_mode_t;

  // Software configuration carried as one bundle
  typedef struct packed {
    logic [1:0] clock_source_select;
    logic direct_use_crystal;
    logic vco_bypass;
    logic [1:0] vco_band_select;
    logic ref_internal;
    logic [3:0] pll_input_divider;
    logic [6:0] pll_feedback_mult;
    logic [6:0] vco_output_divider;
    logic [9:0] osc_prescale_divider;
  } clk_cfg_t;

  // Synchronised clock source levels
  typedef struct packed {
    logic wakeup_osc;
    logic internal_osc;
    logic crystal_input_pin;
    logic direct_clock_input;
  } clk_src_t;

endpackage : clock_select_pkg

// File: pin_sync3.sv
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to clk; one instance per pin.
`timescale 1ns/1ns
module pin_sync3 (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Pin and filtered level
  input wire logic pin_in,
  output logic level_q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_d;

  ////////////////////////////////////////////////////////////////////////////
  // Accept a new level only when stages two and three agree
  always_comb begin
    level_d = (s2_q == s3_q) ? s3_q : level_q;
  end

  // Shift chain; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end else if (clk_en) begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end

endmodule : pin_sync3

// File: system_clock_source_select.sv
// System clock generation and source selection.
// Assumes the clock sources arrive as asynchronous pins and are slow
// compared with clk; the generated clock is a registered level.
`include "clock_select_params.svh"
`timescale 1ns/1ns

// Operation
// - Select 11 drives system clock straight from the direct clock input.
// - A pass-through option uses the crystal input pin instead.
// - Select 10 with bypass set divides oscillator by prescale divider plus one.
// - Prescaler source is crystal or internal oscillator; divide by one passes it.
// - Prescale divider reaches a ratio of 1024 at most.
// - Select 10 with bypass clear gives input times (N+1)/((P+1)(K2+1)).
// - PLL reference is selectable between crystal pin and internal oscillator.
// - PLL steers toward lock gradually, never stepping frequency abruptly.
// - System clock is the VCO output divided by output divider plus one.
// - Band 00 or 01 selects VCO range; codes 1X are reserved.
// - Select 00 runs the system clock from the wakeup oscillator.
module system_clock_source_select
  import clock_select_pkg::*;
#(
  parameter int VCO_PER_W = 16
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Clock sources
  input wire logic direct_clock_input,
  input wire logic crystal_input_pin,
  input wire logic internal_osc,
  input wire logic wakeup_osc,
  // Generated clock and status
  output logic system_clock,
  output logic pll_locked
);

  clk_cfg_t cfg_q;
  clk_cfg_t cfg_d;
  clk_src_t src_pins;
  clk_src_t src;
  clk_mode_t mode_q;
  clk_mode_t mode_d;
  logic [31:0] rdata_d;
  logic ref_lvl;
  logic ref_prev_q;
  logic ref_edge;
  logic osc_prev_q;
  logic osc_change;
  logic direct_lvl;
  logic [9:0] presc_cnt_q;
  logic [9:0] presc_cnt_d;
  logic presc_out_q;
  logic presc_out_d;
  logic [VCO_PER_W-1:0] vco_per_q;
  logic [VCO_PER_W-1:0] vco_per_d;
  logic [VCO_PER_W-1:0] vco_cnt_q;
  logic [VCO_PER_W-1:0] vco_cnt_d;
  logic [VCO_PER_W-1:0] per_min;
  logic [VCO_PER_W-1:0] per_max;
  logic vco_tick;
  logic [3:0] win_cnt_q;
  logic [3:0] win_cnt_d;
  logic [11:0] tick_cnt_q;
  logic [11:0] tick_cnt_d;
  logic [11:0] tick_target;
  logic [6:0] k2_cnt_q;
  logic [6:0] k2_cnt_d;
  logic pll_out_q;
  logic pll_out_d;
  logic locked_d;
  logic sysclk_d;

  ////////////////////////////////////////////////////////////////////////////
  // Source pin synchronisers
  assign src_pins.direct_clock_input = direct_clock_input;
  assign src_pins.crystal_input_pin = crystal_input_pin;
  assign src_pins.internal_osc = internal_osc;
  assign src_pins.wakeup_osc = wakeup_osc;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      pin_sync3 u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .pin_in(src_pins[gi]),
        .level_q(src[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and read data
  always_comb begin
    cfg_d = cfg_q;
    rdata_d = 32'h0000_0000;
    if (reg_wr) begin
      unique case (reg_addr)
        `OFS_SYSTEM_CONTROL_REG0: begin
          if (reg_wdata[`SYSCTL_SEL_MSB:`SYSCTL_SEL_LSB] != `SEL_RESERVED) begin
            cfg_d.clock_source_select =
              reg_wdata[`SYSCTL_SEL_MSB:`SYSCTL_SEL_LSB];
          end
          cfg_d.direct_use_crystal = reg_wdata[`SYSCTL_DIRECT_XTAL];
        end
        `OFS_PLL_CONTROL_REG0: begin
          cfg_d.vco_bypass = reg_wdata[`PLLCTL_BYPASS];
          if (!reg_wdata[`PLLCTL_BAND_MSB]) begin
            cfg_d.vco_band_select =
              reg_wdata[`PLLCTL_BAND_MSB:`PLLCTL_BAND_LSB];
          end
          cfg_d.ref_internal = reg_wdata[`PLLCTL_REF_INT];
          cfg_d.pll_input_divider = reg_wdata[`PLLCTL_P_MSB:`PLLCTL_P_LSB];
          cfg_d.pll_feedback_mult = reg_wdata[`PLLCTL_N_MSB:`PLLCTL_N_LSB];
          cfg_d.vco_output_divider =
            reg_wdata[`PLLCTL_K2_MSB:`PLLCTL_K2_LSB];
        end
        `OFS_PRESCALE_REG: begin
          cfg_d.osc_prescale_divider =
            reg_wdata[`PRESC_K1_MSB:`PRESC_K1_LSB];
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `OFS_SYSTEM_CONTROL_REG0: begin
          rdata_d[`SYSCTL_SEL_MSB:`SYSCTL_SEL_LSB] = cfg_q.clock_source_select;
          rdata_d[`SYSCTL_DIRECT_XTAL] = cfg_q.direct_use_crystal;
        end
        `OFS_PLL_CONTROL_REG0: begin
          rdata_d[`PLLCTL_BYPASS] = cfg_q.vco_bypass;
          rdata_d[`PLLCTL_BAND_MSB:`PLLCTL_BAND_LSB] = cfg_q.vco_band_select;
          rdata_d[`PLLCTL_REF_INT] = cfg_q.ref_internal;
          rdata_d[`PLLCTL_P_MSB:`PLLCTL_P_LSB] = cfg_q.pll_input_divider;
          rdata_d[`PLLCTL_N_MSB:`PLLCTL_N_LSB] = cfg_q.pll_feedback_mult;
          rdata_d[`PLLCTL_K2_MSB:`PLLCTL_K2_LSB] = cfg_q.vco_output_divider;
        end
        `OFS_PRESCALE_REG: begin
          rdata_d[`PRESC_K1_MSB:`PRESC_K1_LSB] = cfg_q.osc_prescale_divider;
        end
        `OFS_STATUS_REG: begin
          rdata_d[`STATUS_MODE_MSB:`STATUS_MODE_LSB] = mode_q;
          rdata_d[`STATUS_LOCK] = pll_locked;
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Active mode decode from the stored selection
  always_comb begin
    unique case (cfg_q.clock_source_select)
      `SEL_DIRECT: mode_d = MODE_DIRECT;
      `SEL_OSC: mode_d = cfg_q.vco_bypass ? MODE_PRESC : MODE_PLL;
      `SEL_WAKEUP: mode_d = MODE_WAKEUP;
      default: mode_d = mode_q;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator choice shared by prescaler and PLL reference
  assign ref_lvl = cfg_q.ref_internal ? src.internal_osc
                                      : src.crystal_input_pin;
  assign ref_edge = ref_lvl & ~ref_prev_q;
  assign osc_change = ref_lvl ^ osc_prev_q;
  assign direct_lvl = cfg_q.direct_use_crystal ? src.crystal_input_pin
                                               : src.direct_clock_input;

  // Prescaler: toggle every K1+1 oscillator edges, period (K1+1) cycles
  always_comb begin
    presc_cnt_d = presc_cnt_q;
    presc_out_d = presc_out_q;
    if (cfg_q.osc_prescale_divider == 10'h000) begin
      presc_cnt_d = 10'h000;
      presc_out_d = ref_lvl;
    end else if (osc_change) begin
      if (presc_cnt_q >= cfg_q.osc_prescale_divider) begin
        presc_cnt_d = 10'h000;
        presc_out_d = ~presc_out_q;
      end else begin
        presc_cnt_d = presc_cnt_q + 10'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PLL model: VCO half-period counter steered by a frequency detector
  always_comb begin
    if (cfg_q.vco_band_select == 2'h1) begin
      per_min = VCO_PER_W'(`BAND1_PER_MIN);
      per_max = VCO_PER_W'(`BAND1_PER_MAX);
    end else begin
      per_min = VCO_PER_W'(`BAND0_PER_MIN);
      per_max = VCO_PER_W'(`BAND0_PER_MAX);
    end
  end

  assign vco_tick = (vco_cnt_q == '0);
  // Two VCO half-periods per VCO cycle, N+1 cycles per P+1 ref cycles
  assign tick_target = {4'h0, ({1'b0, cfg_q.pll_feedback_mult} + 8'h01)}
                       << 1;

  always_comb begin
    vco_cnt_d = vco_tick ? (vco_per_q - 1'b1) : (vco_cnt_q - 1'b1);
    vco_per_d = vco_per_q;
    win_cnt_d = win_cnt_q;
    tick_cnt_d = tick_cnt_q;
    locked_d = pll_locked;
    if (vco_tick && tick_cnt_q != 12'hFFF) begin
      tick_cnt_d = tick_cnt_q + 12'h001;
    end
    if (ref_edge) begin
      if (win_cnt_q >= cfg_q.pll_input_divider) begin
        win_cnt_d = 4'h0;
        tick_cnt_d = {11'h000, vco_tick};
        locked_d = (tick_cnt_q == tick_target);
        // Single-step period change keeps frequency moves smooth
        if (tick_cnt_q < tick_target && vco_per_q > per_min) begin
          vco_per_d = vco_per_q - 1'b1;
        end else if (tick_cnt_q > tick_target && vco_per_q < per_max) begin
          vco_per_d = vco_per_q + 1'b1;
        end
      end else begin
        win_cnt_d = win_cnt_q + 4'h1;
      end
    end
    // Band change pulls the period back inside range one step at a time
    if (vco_per_q < per_min) begin
      vco_per_d = vco_per_q + 1'b1;
    end else if (vco_per_q > per_max) begin
      vco_per_d = vco_per_q - 1'b1;
    end
  end

  // Output divider: toggle every K2+1 half-periods gives (K2+1) VCO cycles
  always_comb begin
    k2_cnt_d = k2_cnt_q;
    pll_out_d = pll_out_q;
    if (vco_tick) begin
      if (k2_cnt_q >= cfg_q.vco_output_divider) begin
        k2_cnt_d = 7'h00;
        pll_out_d = ~pll_out_q;
      end else begin
        k2_cnt_d = k2_cnt_q + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System clock multiplexer
  always_comb begin
    unique case (mode_q)
      MODE_DIRECT: sysclk_d = direct_lvl;
      MODE_PRESC: sysclk_d = presc_out_q;
      MODE_PLL: sysclk_d = pll_out_q;
      MODE_WAKEUP: sysclk_d = src.wakeup_osc;
      default: sysclk_d = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_q <= '0;
      cfg_q.clock_source_select <= `RST_SEL;
      cfg_q.vco_bypass <= `RST_BYPASS;
      cfg_q.vco_band_select <= `RST_BAND;
      mode_q <= MODE_WAKEUP;
      reg_rdata <= 32'h0000_0000;
      ref_prev_q <= 1'b0;
      osc_prev_q <= 1'b0;
      presc_cnt_q <= 10'h000;
      presc_out_q <= 1'b0;
      vco_per_q <= VCO_PER_W'(`RST_VCO_PERIOD);
      vco_cnt_q <= '0;
      win_cnt_q <= 4'h0;
      tick_cnt_q <= 12'h000;
      k2_cnt_q <= 7'h00;
      pll_out_q <= 1'b0;
      pll_locked <= 1'b0;
      system_clock <= 1'b0;
    end else if (clk_en) begin
      cfg_q <= cfg_d;
      mode_q <= mode_d;
      reg_rdata <= rdata_d;
      ref_prev_q <= ref_lvl;
      osc_prev_q <= ref_lvl;
      presc_cnt_q <= presc_cnt_d;
      presc_out_q <= presc_out_d;
      vco_per_q <= vco_per_d;
      vco_cnt_q <= vco_cnt_d;
      win_cnt_q <= win_cnt_d;
      tick_cnt_q <= tick_cnt_d;
      k2_cnt_q <= k2_cnt_d;
      pll_out_q <= pll_out_d;
      pll_locked <= locked_d;
      system_clock <= sysclk_d;
    end
  end

endmodule : system_clock_source_select

// File: clk_sources.sv
// Free-running clock sources on the far side of the selection block.
// Assumes a 10 ns system clock; source edges land 2 ns before its edges.
`timescale 1ns/1ns
module clk_sources #(
  parameter int DIR_HALF = 80,
  parameter int XTAL_HALF = 60,
  parameter int INT_HALF = 50,
  parameter int WAKE_HALF = 200
) (
  // Source levels
  output logic direct_clock_input,
  output logic crystal_input_pin,
  output logic internal_osc,
  output logic wakeup_osc
);
  // Each source toggles on its own half period and never stops
  initial begin
    direct_clock_input = 1'b0;
    crystal_input_pin = 1'b0;
    internal_osc = 1'b0;
    wakeup_osc = 1'b0;
    #3;
    fork
      forever #(DIR_HALF) direct_clock_input = ~direct_clock_input;
      forever #(XTAL_HALF) crystal_input_pin = ~crystal_input_pin;
      forever #(INT_HALF) internal_osc = ~internal_osc;
      forever #(WAKE_HALF) wakeup_osc = ~wakeup_osc;
    join
  end
endmodule : clk_sources

// File: clock_select_properties.sv
// Checker for the clock selection block, bound to its top module.
// Assumes configuration reaches the block only through its register port.
`timescale 1ns/1ns
`include "clock_select_params.svh"
module clock_select_properties
  import clock_select_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Clock sources
  input wire logic direct_clock_input,
  input wire logic crystal_input_pin,
  input wire logic internal_osc,
  input wire logic wakeup_osc,
  // Generated clock and status
  input wire logic system_clock,
  input wire logic pll_locked
);
  localparam clk_cfg_t CFG_RST = '{vco_bypass: 1'b1, default: '0};
  clk_cfg_t cfg_q, cfg_d;
  logic [3:0] quiet_q, quiet_d;
  logic settled, src_dir, src_osc;
  clk_mode_t exp_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the fields the block should hold, refused codes dropped
  always_comb begin
    cfg_d = cfg_q;
    if (reg_wr && reg_addr == `OFS_SYSTEM_CONTROL_REG0) begin
      if (reg_wdata[1:0] != `SEL_RESERVED)
        cfg_d.clock_source_select = reg_wdata[1:0];
      cfg_d.direct_use_crystal = reg_wdata[2];
    end
    if (reg_wr && reg_addr == `OFS_PLL_CONTROL_REG0) begin
      cfg_d.vco_bypass = reg_wdata[0];
      cfg_d.ref_internal = reg_wdata[3];
      if (!reg_wdata[2])
        cfg_d.vco_band_select = reg_wdata[2:1];
    end
    if (reg_wr && reg_addr == `OFS_PRESCALE_REG)
      cfg_d.osc_prescale_divider = reg_wdata[9:0];
    quiet_d = reg_wr ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
  end

  // Shadow registers follow the block's enable and reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_q <= CFG_RST;
      quiet_q <= 4'h0;
    end else if (clk_en) begin
      cfg_q <= cfg_d;
      quiet_q <= quiet_d;
    end
  end

  // Expected mode and selected sources; quiet gives the pipeline time
  assign settled = quiet_q == 4'hF;
  assign exp_mode = (cfg_q.clock_source_select == `SEL_DIRECT) ? MODE_DIRECT :
    (cfg_q.clock_source_select != `SEL_OSC) ? MODE_WAKEUP :
    cfg_q.vco_bypass ? MODE_PRESC : MODE_PLL;
  assign src_dir = cfg_q.direct_use_crystal ? crystal_input_pin
                                            : direct_clock_input;
  assign src_osc = cfg_q.ref_internal ? internal_osc : crystal_input_pin;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Generated clock must rise a few cycles after its source does
  sequence rise_soon;
    ##[2:8] $rose(system_clock);
  endsequence

  mode_status_a: assert property (
    reg_rd && reg_addr == 4'h3 && settled |=> reg_rdata[3:0] == exp_mode)
    else $error("status mode wrong");
  sel_keep_a: assert property (
    reg_rd && reg_addr == 4'h0
    |=> reg_rdata[1:0] == cfg_q.clock_source_select)
    else $error("select readback wrong");
  band_keep_a: assert property (
    reg_rd && reg_addr == 4'h1 |=> reg_rdata[2:1] == cfg_q.vco_band_select)
    else $error("band readback wrong");
  presc_width_a: assert property (
    reg_rd && reg_addr == 4'h2 |=> reg_rdata[31:10] == 22'h0)
    else $error("prescale field too wide");
  direct_follow_a: assert property (
    settled && exp_mode == MODE_DIRECT && !cfg_q.direct_use_crystal &&
    $rose(src_dir) |-> rise_soon) else $error("direct not followed");
  crystal_follow_a: assert property (
    settled && exp_mode == MODE_DIRECT && cfg_q.direct_use_crystal &&
    $rose(src_dir) |-> rise_soon) else $error("crystal not followed");
  wake_follow_a: assert property (
    settled && exp_mode == MODE_WAKEUP && $rose(wakeup_osc) |-> rise_soon)
    else $error("wakeup not followed");
  presc_pass_a: assert property (
    settled && exp_mode == MODE_PRESC && $rose(src_osc) &&
    cfg_q.osc_prescale_divider == 10'h0 |-> rise_soon)
    else $error("divide by one not passed");
endmodule : clock_select_properties

bind system_clock_source_select clock_select_properties i_props (
  .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .direct_clock_input(direct_clock_input),
  .crystal_input_pin(crystal_input_pin), .internal_osc(internal_osc),
  .wakeup_osc(wakeup_osc), .system_clock(system_clock),
  .pll_locked(pll_locked));

// File: tb.sv
// Self-checking bench for the system clock source selection block.
// Assumes the source model and the checker are compiled beforehand.
`timescale 1ns/1ns
module tb
  import clock_select_pkg::*;
();
  // Source periods in clk cycles
  localparam int DIR_P = 16;
  localparam int XTAL_P = 12;
  localparam int INT_P = 10;
  localparam int WAKE_P = 40;
  logic clk, sys_rst, reg_wr, reg_rd, system_clock, pll_locked;
  logic clk_en;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic direct_clock_input, crystal_input_pin, internal_osc, wakeup_osc;
  int mismatches = 0;
  int comparisons = 0;
  int p;
  int n;

  ////////////////////////////////////////////////////////////////////////////
  system_clock_source_select i_dut (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .direct_clock_input(direct_clock_input),
    .crystal_input_pin(crystal_input_pin), .internal_osc(internal_osc),
    .wakeup_osc(wakeup_osc), .system_clock(system_clock),
    .pll_locked(pll_locked));
  clk_sources #(.DIR_HALF(DIR_P * 5), .XTAL_HALF(XTAL_P * 5),
    .INT_HALF(INT_P * 5), .WAKE_HALF(WAKE_P * 5)) i_src (
    .direct_clock_input(direct_clock_input),
    .crystal_input_pin(crystal_input_pin), .internal_osc(internal_osc),
    .wakeup_osc(wakeup_osc));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // Compare one value
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One-cycle write strobe after a rising edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read strobe, data looked at in the following cycle only; m masks bits
  task automatic rdm(input logic [3:0] a, input logic [31:0] m,
                     input logic [31:0] e, input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(nm, reg_rdata & m, e);
  endtask : rdm

  // Full-word read
  task automatic rd(input logic [3:0] a, input logic [31:0] e,
                    input string nm);
    rdm(a, 32'hFFFFFFFF, e, nm);
  endtask : rd

  // Bounded wait at falling edges for a level of the generated clock
  task automatic lvl(input logic v);
    while (system_clock !== v && n < 40000) begin
      @(negedge clk);
      n++;
    end
  endtask : lvl

  // Generated clock period in cycles; the first full period is skipped
  task automatic per(output int q);
    int t0;
    n = 0;
    t0 = 0;
    lvl(1'b0);
    lvl(1'b1);
    repeat (2) begin
      t0 = n;
      lvl(1'b0);
      lvl(1'b1);
    end
    q = n - t0;
    if (n >= 40000) begin
      mismatches++;
      wrap_up();
    end
  endtask : per

  // Let a lock left from the old setting expire, then wait for a new one
  task automatic wait_lock;
    n = 0;
    repeat (200) @(negedge clk);
    while (pll_locked !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    check("lock", {31'h0, pll_locked}, 32'h1);
    if (n >= 3000) wrap_up();
  endtask : wait_lock

  ////////////////////////////////////////////////////////////////////////////
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Main sequence; dividers are set before select 10 is written, then changed while it stays
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(4'h0, 32'h0, "sysctl rst");
    rd(4'h1, 32'h1, "pllctl rst");
    rd(4'h3, {28'h0, MODE_WAKEUP}, "status rst");
    wr(4'h9, 32'hFFFFFFFF);
    rd(4'h9, 32'h0, "unmapped");
    per(p);
    check("wakeup", p, WAKE_P);
    wr(4'h0, 32'h3);
    per(p);
    check("direct", p, DIR_P);
    wr(4'h0, 32'h1);
    rd(4'h0, 32'h3, "sel kept");
    rdm(4'h3, 32'h0000000F, {28'h0, MODE_DIRECT}, "status kept");
    wr(4'h0, 32'h7);
    per(p);
    check("direct xtal", p, XTAL_P);
    wr(4'h1, 32'h1);
    wr(4'h2, 32'h0);
    wr(4'h0, 32'h2);
    rdm(4'h3, 32'h0000000F, {28'h0, MODE_PRESC}, "status presc");
    per(p);
    check("presc 1", p, XTAL_P);
    wr(4'h2, 32'h2);
    per(p);
    check("presc 3", p, 3 * XTAL_P);
    wr(4'h1, 32'h9);
    per(p);
    check("presc int", p, 3 * INT_P);
    wr(4'h2, 32'hE);
    wr(4'h2, 32'h4A);
    wr(4'h2, 32'h176);
    wr(4'h2, 32'hFFFFFFFF);
    rd(4'h2, 32'h3FF, "k1 max");
    // Writes are ignored while the enable is low
    @(posedge clk);
    clk_en <= 1'b0;
    wr(4'h2, 32'h176);
    clk_en <= 1'b1;
    rd(4'h2, 32'h3FF, "k1 frozen");
    per(p);
    check("presc 1024", p, 1024 * INT_P);
    wr(4'h2, 32'hCC);
    wr(4'h2, 32'h28);
    wr(4'h2, 32'h8);
    wr(4'h2, 32'h1);
    wr(4'h2, 32'h0);
    wr(4'h1, 32'h10418);
    wait_lock();
    rd(4'h3, 32'h14, "status pll");
    per(p);
    check("pll", p, INT_P * 2 * 2 / 5);
    wr(4'h1, 32'h1011A);
    rd(4'h1, 32'h1011A, "band 01");
    per(p);
    check("pll gradual", {31'h0, p < INT_P * 2 * 2 / 2}, 32'h1);
    per(p);
    per(p);
    check("pll new", p, INT_P * 2 * 2 / 2);
    wr(4'h1, 32'h1011C);
    rd(4'h1, 32'h1011A, "band 1X");
    wrap_up();
  end
endmodule : tb
